/* File: verilog/sae_alarm_encoder.v */
/*
 * Storage module alarm and status encoder: priority encodes alarm and
 * warning inputs into a display character, the active-low status pair
 * and a supply-enable output, with an APB slave for status and control.
 * Assumes condition inputs synchronous to clk_sys and a held APB master.
 */
`timescale 1ns/1ps
`include "sae_map.vh"

module sae_alarm_encoder #(
    parameter NCOND = `SAE_NCOND
) (
    input  wire              clk_sys,          // System clock, 10 MHz
    input  wire              rst,              // Async reset, active high
    input  wire              isReady,          // Module ready
    input  wire              isCharging,       // Capacitors charging
    input  wire              isDischarging,    // Capacitors discharging
    input  wire [NCOND-3:0]  condIn,           // Alarm and warning detectors
    input  wire              psel,             // APB select
    input  wire              penable,          // APB enable
    input  wire              pwrite,           // APB direction
    input  wire [11:0]       paddr,            // APB byte address
    input  wire [31:0]       pwdata,           // APB write data
    output reg  [31:0]       prdata,           // APB read data
    output reg               pready,           // APB ready
    output reg               pslverr,          // APB error
    output reg  [7:0]        displayChar,      // Front display character
    output reg               abnormality_flag_n, // Abnormality, active low
    output reg               severity_flag_n,  // Serious, active low
    output reg               supplyEnable      // Energy supply path enable
);

    // ****************************************
    // Alarm state and decode signals
    // ****************************************
    reg  [NCOND-3:0] alarmLatch;
    reg  [31:0]      ctrl;
    reg  [4:0]       activeIdx;
    wire             activeAny;
    wire [NCOND-3:0] curCond;
    wire [NCOND-2:0] lowerSet;
    wire [NCOND-3:0] winner;
    reg  [7:0]       next_displayChar;
    reg  [1:0]       next_pair;
    reg              next_supplyEnable;
    wire             latchMode;
    wire             fanOnly;
    integer          i;
    genvar           g;

    // Bit 0: latch alarms until software clears them
    assign latchMode = ctrl[`SAE_CTRL_LATCH];
    assign curCond   = condIn | alarmLatch;
    assign fanOnly   = (curCond == ({{(NCOND-3){1'b0}}, 1'b1} << `SAE_B_FAN));

    // ****************************************
    // Priority chain
    // ****************************************
    // Lowest index wins; serious alarms sit lowest
    assign lowerSet[0] = 1'b0;
    generate
        for (g = 0; g < NCOND - 2; g = g + 1) begin : g_prio
            // An entry wins only if nothing below it is set
            assign winner[g]     = curCond[g] && !lowerSet[g];
            assign lowerSet[g+1] = lowerSet[g] || curCond[g];
        end
    endgenerate
    assign activeAny = lowerSet[NCOND-2];

    // Winner is one-hot, so OR-ing the indices gives its number
    always @* begin
        activeIdx = 5'h00;
        for (i = 0; i < NCOND - 2; i = i + 1) begin
            if (winner[i])
                activeIdx = activeIdx | i[4:0];
        end
    end

    // ****************************************
    // Display code
    // ****************************************

    always @* begin
        next_displayChar = `SAE_CH_DASH;
        if (!activeAny) begin
            if (isCharging)
                next_displayChar = `SAE_CH_ROTR;
            else if (isDischarging)
                next_displayChar = `SAE_CH_ROTL;
            else if (isReady)
                next_displayChar = `SAE_CH_0;
        end else begin
            case (activeIdx)
                `SAE_B_OCRUN:   next_displayChar = `SAE_CH_1;
                `SAE_B_OCREGEN: next_displayChar = `SAE_CH_2;
                `SAE_B_OCCHG:   next_displayChar = `SAE_CH_3;
                `SAE_B_OCDIS:   next_displayChar = `SAE_CH_4;
                `SAE_B_UV24:    next_displayChar = `SAE_CH_5;
                `SAE_B_OVLINK:  next_displayChar = `SAE_CH_6;
                `SAE_B_OVCAP:   next_displayChar = `SAE_CH_7;
                `SAE_B_UVCAP:   next_displayChar = `SAE_CH_8;
                `SAE_B_OTCTL:   next_displayChar = `SAE_CH_9;
                `SAE_B_PSALM:   next_displayChar = `SAE_CH_C;
                `SAE_B_NOCHG:   next_displayChar = `SAE_CH_E;
                `SAE_B_NODIS:   next_displayChar = `SAE_CH_F;
                `SAE_B_BADDIS:  next_displayChar = `SAE_CH_H;
                `SAE_B_OTRES:   next_displayChar = `SAE_CH_J;
                `SAE_B_COMM:    next_displayChar = `SAE_CH_P;
                `SAE_B_CURCTL:  next_displayChar = `SAE_CH_B;
                `SAE_B_FUSE:    next_displayChar = `SAE_CH_HL;
                `SAE_B_FAN:     next_displayChar = `SAE_CH_A;
                `SAE_B_SUPSTP:  next_displayChar = `SAE_CH_U;
                default:        next_displayChar = `SAE_CH_DASH;
            endcase
        end
    end

    // ****************************************
    // Status pair
    // ****************************************
    // Controller relies on pull-downs so an open cable reads serious
    always @* begin
        if (!activeAny)
            next_pair = `SAE_ST_NORMAL;
        else if (activeIdx < `SAE_B_SERIOUS)
            next_pair = `SAE_ST_SERIOUS;
        else
            next_pair = `SAE_ST_ABNORM;
    end

    // ****************************************
    // Supply path
    // ****************************************
    // Fan stop alone keeps the supply path closed
    always @* begin
        next_supplyEnable = isReady && (!activeAny || fanOnly);
    end

    // ****************************************
    // Output registers
    // ****************************************
    // One register stage so display and pair always move together
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            displayChar <= `SAE_CH_DASH;
        end else begin
            displayChar <= next_displayChar;
        end
    end

    // Same edge as the display: severity never lags the abnormality fall
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            severity_flag_n <= 1'b1;
        end else begin
            severity_flag_n <= next_pair[1];
        end
    end

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            abnormality_flag_n <= 1'b1;
        end else begin
            abnormality_flag_n <= next_pair[0];
        end
    end

    // Supply path stays open after reset until the module reports ready
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            supplyEnable <= 1'b0;
        end else begin
            supplyEnable <= next_supplyEnable;
        end
    end

    // ****************************************
    // APB slave
    // ****************************************
    wire        setupPh;
    wire        accessDone;
    wire        wrCtrl;
    wire        wrLatch;
    wire        selStatus;
    wire        selCtrl;
    wire        selLatch;
    wire        selMapped;
    reg  [31:0] readMux;

    assign setupPh    = psel && !penable;
    assign accessDone = psel && penable && pready;
    assign selStatus  = (paddr == `SAE_OFS_STATUS);
    assign selCtrl    = (paddr == `SAE_OFS_CTRL);
    assign selLatch   = (paddr == `SAE_OFS_LATCH);
    assign selMapped  = selStatus || selCtrl || selLatch;
    // Writes land only at the edge that completes the access
    assign wrCtrl     = accessDone && pwrite && selCtrl;
    assign wrLatch    = accessDone && pwrite && selLatch;

    // ****************************************
    // Read path
    // ****************************************
    always @* begin
        readMux = 32'h00000000;
        if (selStatus)
            readMux = {{`SAE_STAT_PAD{1'b0}}, supplyEnable, severity_flag_n,
                       abnormality_flag_n, displayChar, activeAny, activeIdx[2:0]};
        else if (selCtrl)
            readMux = ctrl;
        else if (selLatch)
            readMux = {{(32-NCOND+2){1'b0}}, alarmLatch};
    end

    // Answer one cycle after setup; no further wait states
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
        end else begin
            pready <= setupPh;
        end
    end

    // Unmapped offsets answer with an error and read as zero
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= setupPh && !selMapped;
        end
    end

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prdata <= 32'h00000000;
        end else if (setupPh) begin
            prdata <= readMux;
        end
    end

    // ****************************************
    // Control register
    // ****************************************
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl <= `SAE_CTRL_RST;
        end else if (wrCtrl) begin
            ctrl <= {31'h00000000, pwdata[`SAE_CTRL_LATCH]};
        end
    end

    // ****************************************
    // Alarm latch
    // ****************************************
    // Write-one-to-clear; a condition still present wins over the clear
    always @(posedge clk_sys or posedge rst) begin
        if (rst)
            alarmLatch <= {(NCOND-2){1'b0}};
        else if (latchMode)
            alarmLatch <= (alarmLatch & ~(wrLatch ? pwdata[NCOND-3:0] : {(NCOND-2){1'b0}}))
                          | condIn;
        else
            alarmLatch <= {(NCOND-2){1'b0}};
    end

endmodule

/* File: verilog/sae_map.vh */
/*
 * Constants for the storage alarm and status encoder: display character
 * codes, alarm index bits, status pair encodings and APB offsets.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef SAE_MAP_VH
`define SAE_MAP_VH

// ****************************************
// Display characters (ASCII)
// ****************************************
`define SAE_CH_DASH   8'h2d
`define SAE_CH_0      8'h30
`define SAE_CH_1      8'h31
`define SAE_CH_2      8'h32
`define SAE_CH_3      8'h33
`define SAE_CH_4      8'h34
`define SAE_CH_5      8'h35
`define SAE_CH_6      8'h36
`define SAE_CH_7      8'h37
`define SAE_CH_8      8'h38
`define SAE_CH_9      8'h39
`define SAE_CH_C      8'h43
`define SAE_CH_E      8'h45
`define SAE_CH_F      8'h46
`define SAE_CH_H      8'h48
`define SAE_CH_J      8'h4a
`define SAE_CH_P      8'h50
`define SAE_CH_B      8'h62
`define SAE_CH_HL     8'h68
`define SAE_CH_A      8'h41
`define SAE_CH_U      8'h55
`define SAE_CH_ROTR   8'h3e
`define SAE_CH_ROTL   8'h3c

// ****************************************
// Condition bit positions, in priority order
// ****************************************
`define SAE_NCOND     21
`define SAE_B_OCRUN   0
`define SAE_B_OCREGEN 1
`define SAE_B_OCCHG   2
`define SAE_B_OCDIS   3
`define SAE_B_UV24    4
`define SAE_B_OVLINK  5
`define SAE_B_OVCAP   6
`define SAE_B_UVCAP   7
`define SAE_B_OTCTL   8
`define SAE_B_PSALM   9
`define SAE_B_NOCHG   10
`define SAE_B_NODIS   11
`define SAE_B_BADDIS  12
`define SAE_B_OTRES   13
`define SAE_B_COMM    14
`define SAE_B_CURCTL  15
`define SAE_B_FUSE    16
`define SAE_B_FAN     17
`define SAE_B_SUPSTP  18
`define SAE_B_SERIOUS 7
`define SAE_B_WARN0   17

// ****************************************
// Status pair {severity, abnormality}
// ****************************************
`define SAE_ST_NORMAL  2'b11
`define SAE_ST_ABNORM  2'b10
`define SAE_ST_SERIOUS 2'b00

// ****************************************
// APB map
// ****************************************
`define SAE_OFS_STATUS 12'h000
`define SAE_OFS_CTRL   12'h004
`define SAE_OFS_LATCH  12'h008
`define SAE_CTRL_RST   32'h00000000
`define SAE_CTRL_LATCH 0
`define SAE_STAT_PAD   17

`endif

/* File: sim/sae_alarm_checker.sv */
/*
 * Concurrent checks on the alarm encoder's display and status outputs.
 * Assumes one clock, reset active high, outputs one cycle behind inputs.
 */
`timescale 1ns/1ps
module sae_alarm_checker #(parameter NCOND = 21) (
    input wire logic             clk_sys,            // Clock
    input wire logic             rst,                // Reset
    input wire logic             isReady,            // Ready in
    input wire logic             isCharging,         // Charging in
    input wire logic             isDischarging,      // Discharging in
    input wire logic [NCOND-3:0] condIn,             // Detectors
    input wire logic [7:0]       displayChar,        // Display out
    input wire logic             abnormality_flag_n, // Abnormal out
    input wire logic             severity_flag_n,    // Serious out
    input wire logic             supplyEnable        // Supply out
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire idle = condIn == '0;
    wire quiet = !isCharging && !isDischarging;
    property p_dash; idle && quiet && !isReady |=> displayChar == 8'h2d; endproperty
    property p_zero; idle && quiet && isReady |=> displayChar == 8'h30; endproperty
    property p_run; condIn[0] |=> displayChar == 8'h31; endproperty
    property p_ser; |condIn[6:0] |=> !severity_flag_n && !abnormality_flag_n; endproperty
    property p_abn;
        condIn[6:0] == 7'h00 && |condIn[NCOND-3:7] |=> severity_flag_n && !abnormality_flag_n;
    endproperty
    property p_norm; idle |=> severity_flag_n && abnormality_flag_n; endproperty
    property p_cut; |condIn[16:0] |=> !supplyEnable; endproperty
    // Fan stop alone must not cut the supply path
    property p_fan;
        $onehot(condIn) && condIn[17] && isReady |=> supplyEnable && displayChar == 8'h41;
    endproperty
    property p_sync; $fell(abnormality_flag_n) |-> displayChar != $past(displayChar); endproperty
    a_dash: assert property (p_dash) else $error("dash missing");
    a_zero: assert property (p_zero) else $error("zero missing");
    a_run: assert property (p_run) else $error("code 1 missing");
    a_ser: assert property (p_ser) else $error("serious pair wrong");
    a_abn: assert property (p_abn) else $error("abnormal pair wrong");
    a_norm: assert property (p_norm) else $error("normal pair wrong");
    a_cut: assert property (p_cut) else $error("supply not cut");
    a_fan: assert property (p_fan) else $error("fan stop wrong");
    a_sync: assert property (p_sync) else $error("display stale");
    c_fan: cover property (condIn[17] && isReady);
    c_fall: cover property ($fell(abnormality_flag_n));
    c_chg: cover property (isCharging && idle);
endmodule
bind sae_alarm_encoder sae_alarm_checker #(.NCOND(NCOND)) chk_inst (
    .clk_sys(clk_sys), .rst(rst), .isReady(isReady), .isCharging(isCharging),
    .isDischarging(isDischarging), .condIn(condIn), .displayChar(displayChar),
    .abnormality_flag_n(abnormality_flag_n), .severity_flag_n(severity_flag_n),
    .supplyEnable(supplyEnable));

/* File: sim/sae_plc_model.sv */
/*
 * Controller model reading the status pair through pulled-down inputs.
 * Assumes flags registered on clk_sys; actions latch until clrIn.
 */
`timescale 1ns/1ps
module sae_plc_model (
    input  wire logic clk_sys,            // Clock
    input  wire logic clrIn,              // Clear actions
    input  wire logic cableOk,            // Cable connected
    input  wire logic abnormality_flag_n, // Abnormal line
    input  wire logic severity_flag_n,    // Serious line
    output logic      safeMove,           // Reposition started
    output logic      emergencyStop,      // Emergency stop
    output logic      contactorOpen       // Contactor opened
);
    wire abnIn = cableOk & abnormality_flag_n;
    wire sevIn = cableOk & severity_flag_n;
    logic abnQ;
    always @(posedge clk_sys or posedge clrIn) begin
        if (clrIn) begin
            {abnQ, safeMove, emergencyStop, contactorOpen} <= 4'h8;
        end else begin
            abnQ <= abnIn;
            if (abnQ && !abnIn && !sevIn) begin
                {emergencyStop, contactorOpen} <= 2'b11;
            end else if (abnQ && !abnIn) begin
                safeMove <= 1'b1;
            end else if (safeMove) begin
                {emergencyStop, contactorOpen} <= 2'b11;
            end
        end
    end
endmodule

/* File: sim/sae_alarm_encoder_tb.sv */
/*
 * Self-checking bench for the alarm encoder, its APB port and controller.
 * Assumes the design's one-cycle output latency and zero-wait APB slave.
 */
`timescale 1ns/1ps
module sae_alarm_encoder_tb;
    logic clk_sys = 0, rst = 1, isReady = 0, isCharging = 0, isDischarging = 0;
    logic psel = 0, penable = 0, pwrite = 0, plcClr = 1, cableOk = 1;
    logic [18:0] condIn = '0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, abnormality_flag_n, severity_flag_n, supplyEnable, err;
    logic safeMove, emergencyStop, contactorOpen;
    logic [7:0] displayChar;
    logic [7:0] codes [19] = '{8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h37, 8'h38,
        8'h39, 8'h43, 8'h45, 8'h46, 8'h48, 8'h4a, 8'h50, 8'h62, 8'h68, 8'h41, 8'h55};
    int num_errors = 0, compares = 0;
    sae_alarm_encoder sae_alarm_encoder_inst (.clk_sys(clk_sys), .rst(rst),
        .isReady(isReady), .isCharging(isCharging), .isDischarging(isDischarging),
        .condIn(condIn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .displayChar(displayChar), .abnormality_flag_n(abnormality_flag_n),
        .severity_flag_n(severity_flag_n), .supplyEnable(supplyEnable));
    sae_plc_model sae_plc_model_inst (.clk_sys(clk_sys), .clrIn(plcClr), .cableOk(cableOk),
        .abnormality_flag_n(abnormality_flag_n), .severity_flag_n(severity_flag_n),
        .safeMove(safeMove), .emergencyStop(emergencyStop), .contactorOpen(contactorOpen));
    always #50 clk_sys = ~clk_sys;
    // ****************************************
    // Tasks
    // ****************************************
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task give_verdict;
        if (num_errors == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task put(input logic [18:0] c, input logic r, input logic ch, input logic di);
        @(posedge clk_sys);
        condIn <= c;
        isReady <= r;
        isCharging <= ch;
        isDischarging <= di;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task plcReset;
        @(posedge clk_sys);
        plcClr <= 1'b1;
        @(posedge clk_sys);
        plcClr <= 1'b0;
    endtask
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        #200us;
        num_errors++;
        give_verdict;
    end
    initial begin
        repeat (10) @(posedge clk_sys);
        rst <= 0;
        plcClr <= 0;
        put(0, 0, 0, 0);
        chk({supplyEnable, displayChar}, 9'h02d);
        put(0, 1, 0, 0);
        chk({supplyEnable, displayChar}, 9'h130);
        put(0, 1, 1, 0);
        chk({severity_flag_n, abnormality_flag_n, displayChar}, 10'h33e);
        put(0, 1, 0, 1);
        chk({severity_flag_n, abnormality_flag_n, displayChar}, 10'h33c);
        // Each detector alone, then the lowest index must win over a warning
        for (int i = 0; i < 19; i++) begin
            put(19'h1 << i, 1, 0, 0);
            chk(displayChar, codes[i]);
            chk({severity_flag_n, abnormality_flag_n}, (i < 7) ? 2'b00 : 2'b10);
            chk(supplyEnable, i == 17);
        end
        put(19'h40001, 1, 0, 0);
        chk(displayChar, 8'h31);
        apb(0, 12'h000, 0);
        chk({err, rd}, 33'h000000318);
        apb(1, 12'h004, 32'h1);
        apb(0, 12'h004, 0);
        chk(rd, 32'h1);
        apb(1, 12'h004, 0);
        apb(0, 12'h00c, 0);
        chk({err, rd}, 33'h100000000);
        put(0, 1, 0, 0);
        plcReset;
        put(19'h1, 1, 0, 0);
        chk({safeMove, emergencyStop, contactorOpen}, 3'b011);
        put(0, 1, 0, 0);
        plcReset;
        put(19'h80, 1, 0, 0);
        chk({safeMove, emergencyStop, contactorOpen}, 3'b111);
        put(0, 1, 0, 0);
        plcReset;
        cableOk <= 0;
        put(0, 1, 0, 0);
        chk({safeMove, emergencyStop, contactorOpen}, 3'b011);
        give_verdict;
    end
endmodule
